// *** design/srd_consts.svh ***
`ifndef SRD_CONSTS_SVH
`define SRD_CONSTS_SVH

// ----------------------------------------
// register bus offsets
// ----------------------------------------
`define SRD_OFF_STATUS 4'h0
`define SRD_OFF_MODE 4'h1
`define SRD_OFF_PC 4'h2
`define SRD_OFF_RESULT 4'h3
`define SRD_OFF_ACC0 4'h4
`define SRD_OFF_ACC1 4'h5
`define SRD_OFF_ACC2 4'h6
`define SRD_OFF_ACC3 4'h7
`define SRD_OFF_MDR 4'h8
`define SRD_OFF_MAR 4'h9

// ----------------------------------------
// status byte field positions
// ----------------------------------------
`define SRD_FLAG_LINK 7
`define SRD_FLAG_OVF 6
`define SRD_FLAG_CARRY 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define SRD_RST_BYTE 8'h00
`define SRD_RST_PC 8'hFE
`define SRD_RST_RING 8'h01

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SRD_T4_EXTRA 2'h3

`endif

// *** design/srd_pkg.sv ***
package srd_pkg;
	// alu function field, phase five low bits
	typedef enum logic [1:0] {
		SRD_ALU_AND,
		SRD_ALU_XOR,
		SRD_ALU_OR,
		SRD_ALU_ADD
	} srd_alu_fn_t;

	// shift/extend function field, phase five high bits
	typedef enum logic [1:0] {
		SRD_SH_NONE,
		SRD_SH_EXTEND,
		SRD_SH_LEFT,
		SRD_SH_RIGHT
	} srd_shift_fn_t;
endpackage

// *** design/srd_stack.sv ***
`timescale 1ns/100ps
// push-down stack of one slice, flip-flop storage
module srd_stack #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// stack control
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [WIDTH-1:0] i_din,
	// top entry
	output logic [WIDTH-1:0] o_top
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	// -----------------------------------
	// entry shifting
	// -----------------------------------
	// pop then push in one edge just replaces the top
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (i_push && i_pop) begin
			mem_q[0] <= i_din;
		end else if (i_push) begin
			// every entry down one level, bottom lost
			for (int i = DEPTH - 1; i > 0; i--) begin // RULE_01
				mem_q[i] <= mem_q[i-1];
			end
			mem_q[0] <= i_din;
		end else if (i_pop) begin
			// every entry up one level, zero into bottom
			for (int i = 0; i < DEPTH - 1; i++) begin // RULE_02
				mem_q[i] <= mem_q[i+1];
			end
			mem_q[DEPTH-1] <= '0; // RULE_02
		end
	end

	assign o_top = mem_q[0];
endmodule

// *** design/srd_datapath.sv ***
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`include "srd_consts.svh"

// Summary of operation
// RULE_01 - sixteen-deep stack per slice, push shifts down
// RULE_02 - pop shifts up, zero into bottom
// RULE_03 - status byte: link, overflow, carry, five flags
// RULE_04 - byte counter increments after each fetch
// RULE_05 - skip advances byte counter by two
// RULE_06 - branch loads target into byte counter
// RULE_07 - byte counter is low address half
// RULE_08 - alu does add, and, or, xor
// RULE_09 - complement bit inverts first operand
// RULE_10 - shifter moves at most one bit
// RULE_11 - out via first operand, in via result
// RULE_12 - four control nibbles latched per microcycle; three latched here, phase seven nibble used live
// RULE_13 - eight intervals, fourth stretched on memory
// RULE_14 - eight-stage ring counter, one tap each
// RULE_15 - memory cycle holds ring three clocks
// RULE_16 - strobes at first, third, fifth, seventh
// RULE_17 - phase one selects first operand source
// RULE_18 - phase three selects second operand source
// RULE_19 - phase five: alu and shift fields
// RULE_20 - extension fills upper nibble, zero or sign
// RULE_21 - stack top and flag nibbles as byte
// RULE_22 - result goes to register, stack, output
// RULE_23 - alu codes: and, xor, or, add
// RULE_24 - shift codes: none, extend, left, right
// RULE_25 - phase seven writes register or pushes
// RULE_26 - line three picks alu or input data
// RULE_27 - register field mapping fixed here
module srd_datapath (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// control bus from sequencer
	input wire logic [3:0] i_ctrl_nibble,
	input wire logic i_mem_cycle,
	input wire logic i_byte_fetched,
	input wire logic i_skip,
	// external data and page
	input wire logic [7:0] i_ext_data,
	input wire logic [7:0] i_page,
	// register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// timing outputs
	output logic [7:0] o_ring,
	output logic o_phase_strobe_first,
	output logic o_phase_strobe_third,
	output logic o_phase_strobe_fifth,
	output logic o_phase_strobe_seventh,
	// data and address outputs
	output logic [7:0] o_data_out,
	output logic [7:0] o_rbus_out,
	output logic [15:0] o_mem_addr,
	output logic [7:0] o_status
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] ring_q; // one-hot interval taps
	logic [7:0] ring_d; // next taps
	logic [1:0] hold_q; // stretch counter at fourth interval
	logic mem_q; // memory cycle seen at first interval
	logic [3:0] ph1_q; // phase one nibble
	logic [3:0] ph3_q; // phase three nibble
	logic [3:0] ph5_q; // phase five nibble
	logic [7:0] acc0_q; // accumulator_zero
	logic [7:0] acc1_q; // accumulator_one
	logic [7:0] acc2_q; // accumulator_two
	logic [7:0] acc3_q; // accumulator_three
	logic [7:0] pc_q; // byte_program_counter
	logic [7:0] mdr_q; // memory_data_reg
	logic [7:0] mar_q; // memory_address_reg
	logic [7:0] status_q; // status_flag_byte
	logic flag_view_q; // mode: stack and flags as one byte
	logic [7:0] result_q; // last result bus value
	logic [7:0] stack_top; // top of both slices
	logic [7:0] a_bus; // first operand bus
	logic [7:0] b_bus; // second operand bus
	logic [7:0] a_alu; // operand after complementer
	logic [8:0] sum; // adder with carry out
	logic [7:0] alu_out; // alu result
	logic [7:0] shift_out; // shifter result
	logic [7:0] r_bus; // result bus
	logic shift_spill; // bit shifted out
	logic add_ovf; // signed overflow of add
	logic exec_t7; // seventh-interval execution edge
	logic do_push; // stack push this edge
	logic do_pop; // stack pop this edge
	logic [2:0] dest; // phase seven destination
	srd_pkg::srd_alu_fn_t alu_fn; // decoded alu field
	srd_pkg::srd_shift_fn_t sh_fn; // decoded shift field

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// register field to register value, zero for field zero
	function automatic logic [7:0] reg_pick(input logic [2:0] field,
		input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2,
		input logic [7:0] a3, input logic [7:0] pc, input logic [7:0] md,
		input logic [7:0] ma);
		logic [7:0] val;
		val = 8'h00;
		case (field) // RULE_27
			3'h1: val = a0;
			3'h2: val = a1;
			3'h3: val = a2;
			3'h4: val = a3;
			3'h5: val = pc;
			3'h6: val = md;
			3'h7: val = ma;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	// ----------------------------------------
	// ring counter and interval stretch
	// ----------------------------------------
	// next ring value, held at fourth tap while stretching
	always_comb begin
		ring_d = {ring_q[6:0], ring_q[7]}; // RULE_14
		if (ring_q[3] && mem_q && hold_q != `SRD_T4_EXTRA) begin
			ring_d = ring_q; // RULE_15
		end
	end

	// ring register, one step per clock except while held at fourth tap
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ring_q <= `SRD_RST_RING;
		end else begin
			ring_q <= ring_d; // RULE_13
		end
	end

	// stretch counter counts extra clocks at fourth tap
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_q <= 2'h0;
		end else if (ring_q[3] && mem_q && hold_q != `SRD_T4_EXTRA) begin
			hold_q <= hold_q + 2'h1; // RULE_15
		end else begin
			hold_q <= 2'h0;
		end
	end

	// memory request taken at first interval for the whole microcycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem_q <= 1'b0;
		end else if (ring_q[0]) begin
			mem_q <= i_mem_cycle; // RULE_13
		end
	end

	// phase strobes follow odd taps, registered with the ring
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_phase_strobe_first <= 1'b1;
			o_phase_strobe_third <= 1'b0;
			o_phase_strobe_fifth <= 1'b0;
			o_phase_strobe_seventh <= 1'b0;
		end else begin
			o_phase_strobe_first <= ring_d[0]; // RULE_16
			o_phase_strobe_third <= ring_d[2]; // RULE_16
			o_phase_strobe_fifth <= ring_d[4]; // RULE_16
			o_phase_strobe_seventh <= ring_d[6]; // RULE_16
		end
	end

	assign o_ring = ring_q;

	// ----------------------------------------
	// control nibble latches
	// ----------------------------------------
	// each nibble taken on its own phase interval
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph1_q <= 4'h0;
			ph3_q <= 4'h0;
			ph5_q <= 4'h0;
		end else begin
			if (ring_q[0]) begin
				ph1_q <= i_ctrl_nibble; // RULE_12
			end
			if (ring_q[2]) begin
				ph3_q <= i_ctrl_nibble; // RULE_12
			end
			if (ring_q[4]) begin
				ph5_q <= i_ctrl_nibble; // RULE_12
			end
		end
	end

	// phase seven nibble is used live at the execution edge
	assign exec_t7 = ring_q[6];
	assign dest = i_ctrl_nibble[2:0];
	assign alu_fn = srd_pkg::srd_alu_fn_t'(ph5_q[1:0]); // RULE_19
	assign sh_fn = srd_pkg::srd_shift_fn_t'(ph5_q[3:2]); // RULE_19

	// ----------------------------------------
	// operand buses
	// ----------------------------------------
	// first operand: register, stack top, flag view or zero
	always_comb begin
		a_bus = reg_pick(ph1_q[2:0], acc0_q, acc1_q, acc2_q, acc3_q,
			pc_q, mdr_q, mar_q); // RULE_17
		if (ph1_q[2:0] == 3'h0) begin
			if (!ph1_q[3]) begin
				a_bus = 8'h00; // RULE_17
			end else if (flag_view_q) begin
				a_bus = {status_q[7:4], stack_top[3:0]}; // RULE_21
			end else begin
				a_bus = stack_top; // RULE_17
			end
		end
	end

	// second operand: register or zero
	assign b_bus = reg_pick(ph3_q[2:0], acc0_q, acc1_q, acc2_q, acc3_q,
		pc_q, mdr_q, mar_q); // RULE_18

	// complementer in front of the alu
	assign a_alu = ph3_q[3] ? ~a_bus : a_bus; // RULE_09

	// ----------------------------------------
	// alu, shifter and result bus
	// ----------------------------------------
	assign sum = {1'b0, a_alu} + {1'b0, b_bus}; // RULE_08
	assign add_ovf = (a_alu[7] == b_bus[7]) && (sum[7] != a_alu[7]);

	// alu function decode, never suppressed by shift no-op
	always_comb begin
		case (alu_fn) // RULE_23
			srd_pkg::SRD_ALU_AND: alu_out = a_alu & b_bus;
			srd_pkg::SRD_ALU_XOR: alu_out = a_alu ^ b_bus;
			srd_pkg::SRD_ALU_OR: alu_out = a_alu | b_bus;
			srd_pkg::SRD_ALU_ADD: alu_out = sum[7:0];
			default: alu_out = 8'h00;
		endcase
	end

	// shifter: one position at most, spilled bit goes to link
	always_comb begin
		shift_out = alu_out;
		shift_spill = status_q[`SRD_FLAG_LINK];
		case (sh_fn) // RULE_24
			srd_pkg::SRD_SH_NONE: shift_out = alu_out;
			srd_pkg::SRD_SH_EXTEND: begin
				// fill upper nibble with bit three when live line three is set, else with zero
				shift_out = {{4{i_ctrl_nibble[3] & alu_out[3]}}, alu_out[3:0]}; // RULE_20
			end
			srd_pkg::SRD_SH_LEFT: begin
				shift_out = {alu_out[6:0], 1'b0}; // RULE_10
				shift_spill = alu_out[7];
			end
			srd_pkg::SRD_SH_RIGHT: begin
				shift_out = {1'b0, alu_out[7:1]}; // RULE_10
				shift_spill = alu_out[0];
			end
			default: shift_out = alu_out;
		endcase
	end

	// result source: alu path or external input data
	always_comb begin
		r_bus = shift_out;
		if (sh_fn != srd_pkg::SRD_SH_EXTEND && i_ctrl_nibble[3]) begin
			r_bus = i_ext_data; // RULE_26 RULE_11
		end
	end

	// ----------------------------------------
	// stack slices
	// ----------------------------------------
	assign do_pop = exec_t7 && ph1_q[2:0] == 3'h0 && ph1_q[3];
	assign do_push = exec_t7 && dest == 3'h0 && ph1_q[3]; // RULE_25 RULE_22

	// low slice
	srd_stack #(
		.WIDTH(4),
		.DEPTH(16)
	) u_stack_lo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_push(do_push),
		.i_pop(do_pop),
		.i_din(r_bus[3:0]),
		.o_top(stack_top[3:0])
	);

	// high slice
	srd_stack #(
		.WIDTH(4),
		.DEPTH(16)
	) u_stack_hi (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_push(do_push),
		.i_pop(do_pop),
		.i_din(r_bus[7:4]),
		.o_top(stack_top[7:4])
	);

	// ----------------------------------------
	// working registers
	// ----------------------------------------
	// accumulators and memory registers loaded from result bus
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc0_q <= `SRD_RST_BYTE;
			acc1_q <= `SRD_RST_BYTE;
			acc2_q <= `SRD_RST_BYTE;
			acc3_q <= `SRD_RST_BYTE;
			mdr_q <= `SRD_RST_BYTE;
			mar_q <= `SRD_RST_BYTE;
		end else if (exec_t7) begin
			case (dest) // RULE_25 RULE_22 RULE_27
				3'h1: acc0_q <= r_bus;
				3'h2: acc1_q <= r_bus;
				3'h3: acc2_q <= r_bus;
				3'h4: acc3_q <= r_bus;
				3'h6: mdr_q <= r_bus;
				3'h7: mar_q <= r_bus;
				default: ;
			endcase
		end
	end

	// byte counter: branch load beats skip beats fetch increment
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pc_q <= `SRD_RST_PC;
		end else if (exec_t7 && dest == 3'h5) begin
			pc_q <= r_bus; // RULE_06
		end else if (i_skip) begin
			pc_q <= pc_q + 8'h02; // RULE_05
		end else if (i_byte_fetched) begin
			pc_q <= pc_q + 8'h01; // RULE_04
		end
	end

	// last result, offered back out at second interval
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			result_q <= `SRD_RST_BYTE;
		end else if (exec_t7) begin
			result_q <= r_bus; // RULE_22
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// software write first, hardware update at execution wins
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_q <= `SRD_RST_BYTE;
		end else begin
			if (i_reg_wr && i_reg_addr == `SRD_OFF_STATUS) begin
				status_q <= i_reg_wdata; // RULE_03
			end
			if (exec_t7 && alu_fn == srd_pkg::SRD_ALU_ADD) begin
				status_q[`SRD_FLAG_CARRY] <= sum[8]; // RULE_03
				status_q[`SRD_FLAG_OVF] <= add_ovf; // RULE_03
			end
			if (exec_t7 && (sh_fn == srd_pkg::SRD_SH_LEFT ||
				sh_fn == srd_pkg::SRD_SH_RIGHT)) begin
				status_q[`SRD_FLAG_LINK] <= shift_spill; // RULE_03
			end
		end
	end

	// mode register
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_view_q <= 1'b0;
		end else if (i_reg_wr && i_reg_addr == `SRD_OFF_MODE) begin
			flag_view_q <= i_reg_wdata[0];
		end
	end

	// ----------------------------------------
	// external outputs
	// ----------------------------------------
	// data out only from first operand bus at fourth interval
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data_out <= `SRD_RST_BYTE;
		end else if (ring_q[3] && hold_q == 2'h0) begin
			o_data_out <= a_bus; // RULE_11
		end
	end

	// previous result out at second interval
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rbus_out <= `SRD_RST_BYTE;
		end else if (ring_q[1]) begin
			o_rbus_out <= result_q;
		end
	end

	// full address: page high, byte counter low; flag mirror
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem_addr <= 16'h0000;
			o_status <= `SRD_RST_BYTE;
		end else begin
			o_mem_addr <= {i_page, pc_q}; // RULE_07
			o_status <= status_q;
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	// read data one cycle after strobe, zero when unmapped
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`SRD_OFF_STATUS: o_reg_rdata <= status_q;
				`SRD_OFF_MODE: o_reg_rdata <= {7'h00, flag_view_q};
				`SRD_OFF_PC: o_reg_rdata <= pc_q;
				`SRD_OFF_RESULT: o_reg_rdata <= result_q;
				`SRD_OFF_ACC0: o_reg_rdata <= acc0_q;
				`SRD_OFF_ACC1: o_reg_rdata <= acc1_q;
				`SRD_OFF_ACC2: o_reg_rdata <= acc2_q;
				`SRD_OFF_ACC3: o_reg_rdata <= acc3_q;
				`SRD_OFF_MDR: o_reg_rdata <= mdr_q;
				`SRD_OFF_MAR: o_reg_rdata <= mar_q;
				default: o_reg_rdata <= 8'h00;
			endcase
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end
endmodule

// *** sim/srd_datapath_assertions.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the sliced datapath
// ----------------------------------------
module srd_datapath_chk (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// inputs watched
	input wire logic [3:0] i_ctrl_nibble,
	input wire logic i_mem_cycle,
	input wire logic i_byte_fetched,
	input wire logic i_skip,
	input wire logic [7:0] i_ext_data,
	input wire logic [7:0] i_page,
	// outputs watched
	input wire logic [7:0] o_ring,
	input wire logic o_phase_strobe_first,
	input wire logic o_phase_strobe_third,
	input wire logic o_phase_strobe_fifth,
	input wire logic o_phase_strobe_seventh,
	input wire logic [7:0] o_data_out,
	input wire logic [7:0] o_rbus_out,
	input wire logic [15:0] o_mem_addr
);
	default clocking dcb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic [1:0] sh_q; // shift field seen at phase five
	logic br_any; // byte counter load at the execution edge
	logic br_ext; // same load, fed from external input
	// keep the shift field until the execution edge
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_q <= 2'h0;
		end else if (o_ring[4]) begin
			sh_q <= i_ctrl_nibble[3:2];
		end
	end
	assign br_any = o_ring[6] && (i_ctrl_nibble[2:0] == 3'h5);
	assign br_ext = br_any && i_ctrl_nibble[3] && (sh_q != 2'h1);
	// interval walk without memory access
	sequence s_plain;
		o_ring[1] ##1 o_ring[2] ##1 o_ring[3] ##1 o_ring[4] ##1 o_ring[5] ##1 o_ring[6]
			##1 o_ring[7] ##1 o_ring[0];
	endsequence
	// memory request held through the stretch
	sequence s_mem_hold;
		o_ring[0] && i_mem_cycle ##1 i_mem_cycle [*6];
	endsequence
	a_ring_onehot: assert property ($onehot(o_ring))
		else $error("ring taps not one-hot");
	a_ring_plain: assert property (o_ring[0] && !i_mem_cycle |=> s_plain)
		else $error("plain microcycle walk wrong");
	a_mem_stretch: assert property (s_mem_hold |-> o_ring[3] ##1 o_ring[4])
		else $error("fourth interval not held four clocks");
	a_strobe_taps: assert property ({o_phase_strobe_seventh, o_phase_strobe_fifth,
		o_phase_strobe_third, o_phase_strobe_first} == {o_ring[6], o_ring[4], o_ring[2], o_ring[0]})
		else $error("phase strobes off their intervals");
	a_pc_fetch: assert property (i_byte_fetched && !i_skip && !br_any
		|=> ##1 (o_mem_addr[7:0] == $past(o_mem_addr[7:0]) + 8'h01))
		else $error("fetch did not add one");
	a_pc_skip: assert property (i_skip && !br_any
		|=> ##1 (o_mem_addr[7:0] == $past(o_mem_addr[7:0]) + 8'h02))
		else $error("skip did not add two");
	a_pc_branch: assert property (br_ext |=> ##1 (o_mem_addr[7:0] == $past(i_ext_data, 2)))
		else $error("branch target not loaded");
	a_addr_page: assert property ($past(i_rst_n) |-> o_mem_addr[15:8] == $past(i_page))
		else $error("page half of address wrong");
	a_dout_timing: assert property ($changed(o_data_out)
		|-> $past(o_ring[3]) && !$past(o_ring[3], 2))
		else $error("data out moved outside first T4 clock");
	a_rbus_timing: assert property ($changed(o_rbus_out) |-> $past(o_ring[1]))
		else $error("result out moved outside T2");
endmodule

// *** sim/srd_seq_model.sv ***
`timescale 1ns/100ps
// behavioural sequencer: plays one microinstruction per microcycle
module srd_seq_model (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// microinstruction from the bench
	input wire logic [15:0] i_uinst,
	input wire logic i_mem,
	// interval taps from the datapath
	input wire logic [7:0] i_ring,
	// control bus to the datapath
	output logic [3:0] o_ctrl_nibble,
	output logic o_mem_cycle
);
	logic [15:0] uinst_q; // microinstruction being played
	logic mem_q; // memory flag, held for the whole microcycle
	// take the next word as T8 closes
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			uinst_q <= 16'h0000;
			mem_q <= 1'b0;
		end else if (i_ring[7]) begin
			uinst_q <= i_uinst;
			mem_q <= i_mem;
		end
	end
	assign o_mem_cycle = mem_q;
	// one nibble in each odd interval, inverted junk in between
	always_comb begin
		case (1'b1)
			i_ring[0]: o_ctrl_nibble = uinst_q[3:0];
			i_ring[1]: o_ctrl_nibble = ~uinst_q[3:0];
			i_ring[2]: o_ctrl_nibble = uinst_q[7:4];
			i_ring[3]: o_ctrl_nibble = ~uinst_q[7:4];
			i_ring[4]: o_ctrl_nibble = uinst_q[11:8];
			i_ring[5]: o_ctrl_nibble = ~uinst_q[11:8];
			i_ring[6]: o_ctrl_nibble = uinst_q[15:12];
			default: o_ctrl_nibble = ~uinst_q[15:12];
		endcase
	end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`include "srd_consts.svh"
module tb_top;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic ref_clk;
	logic rst_n = 1'b0;
	logic [15:0] uinst = 16'h0000; // next microinstruction
	logic mem = 1'b0;
	logic fetched = 1'b0;
	logic skip = 1'b0;
	logic [7:0] ext = 8'h00;
	logic [7:0] page = 8'h3C;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [3:0] nib;
	logic mem_cyc;
	wire [3:0] ph; // strobes first to seventh
	logic [7:0] rdata, ring, dout, rbus, status;
	logic [15:0] maddr;
	int mismatches = 0;
	int compares = 0;
	srd_seq_model i_srd_seq_model (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_uinst(uinst),
		.i_mem(mem), .i_ring(ring), .o_ctrl_nibble(nib), .o_mem_cycle(mem_cyc));
	srd_datapath i_srd_datapath (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ctrl_nibble(nib),
		.i_mem_cycle(mem_cyc), .i_byte_fetched(fetched), .i_skip(skip), .i_ext_data(ext),
		.i_page(page), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr_en),
		.i_reg_rd(rd_en), .o_reg_rdata(rdata), .o_ring(ring), .o_phase_strobe_first(ph[0]),
		.o_phase_strobe_third(ph[1]), .o_phase_strobe_fifth(ph[2]),
		.o_phase_strobe_seventh(ph[3]), .o_data_out(dout), .o_rbus_out(rbus),
		.o_mem_addr(maddr), .o_status(status));
	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		chk(what, {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	// fields: a-source, stack bit, b-source, complement, alu, shift, dest, line three
	function automatic logic [15:0] mk(logic [2:0] a, logic s, logic [2:0] b, logic c,
		logic [1:0] f, logic [1:0] h, logic [2:0] d, logic e);
		return {e, d, h, f, c, b, s, a};
	endfunction
	// stop at the next T8, counting clocks spent
	task automatic wait_t8(output int n);
		n = 0;
		@(negedge ref_clk);
		while (ring[7] !== 1'b1 && n < 40) begin
			n++;
			@(negedge ref_clk);
		end
	endtask
	// play one microcycle; returns at its T8 with n+1 clocks used
	task automatic uc(input logic [15:0] u, input logic m, input logic [7:0] x, output int n);
		@(posedge ref_clk);
		uinst <= u;
		mem <= m;
		ext <= x;
		wait_t8(n);
		@(posedge ref_clk);
		uinst <= 16'h0000;
		mem <= 1'b0;
		wait_t8(n);
	endtask
	// load a register from external input
	task automatic ld(input logic [2:0] d, input logic [7:0] v);
		int n;
		uc(mk(3'h0, 1'b0, 3'h0, 1'b0, 2'h0, 2'h0, d, 1'b1), 1'b0, v, n);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_pc;
		int n;
		rchk("status_reset", `SRD_OFF_STATUS, 8'h00);
		rchk("pc_reset", `SRD_OFF_PC, 8'hFE);
		chk("addr_reset", maddr, {page, 8'hFE});
		@(posedge ref_clk);
		fetched <= 1'b1;
		@(posedge ref_clk);
		fetched <= 1'b0;
		rchk("pc_fetch", `SRD_OFF_PC, 8'hFF);
		@(posedge ref_clk);
		skip <= 1'b1;
		@(posedge ref_clk);
		skip <= 1'b0;
		page <= 8'hC3;
		rchk("pc_skip", `SRD_OFF_PC, 8'h01);
		uc(mk(3'h0, 1'b0, 3'h0, 1'b0, 2'h0, 2'h0, 3'h5, 1'b1), 1'b0, 8'h40, n);
		wr(`SRD_OFF_PC, 8'h55);
		rchk("pc_branch", `SRD_OFF_PC, 8'h40);
		chk("addr_branch", maddr, 16'hC340);
		rchk("unmapped", 4'hF, 8'h00);
		$display("t_pc done");
	endtask
	task automatic t_alu;
		int n;
		logic [7:0] a;
		logic [7:0] r [4];
		ld(3'h1, 8'h6C);
		ld(3'h2, 8'h3A);
		for (int c = 0; c < 2; c++) begin
			a = c ? 8'h93 : 8'h6C;
			r = '{a & 8'h3A, a ^ 8'h3A, a | 8'h3A, a + 8'h3A};
			for (int f = 0; f < 4; f++) begin
				uc(mk(3'h1, c[0], 3'h2, c[0], f[1:0], 2'h0, 3'h3, 1'b0), 1'b0, 8'hFF, n);
				chk("data_out", {8'h00, dout}, 16'h006C);
				rchk("alu_result", `SRD_OFF_ACC2, r[f]);
			end
		end
		uc(mk(3'h0, 1'b0, 3'h0, 1'b0, 2'h2, 2'h0, 3'h3, 1'b0), 1'b0, 8'hFF, n);
		rchk("zero_sources", `SRD_OFF_ACC2, 8'h00);
		$display("t_alu done");
	endtask
	task automatic t_shift;
		int n;
		logic [1:0] h [4];
		logic [7:0] r [4];
		h = '{2'h2, 2'h3, 2'h1, 2'h1};
		r = '{8'h36, 8'h4D, 8'h0B, 8'hFB};
		ld(3'h1, 8'h9B);
		for (int i = 0; i < 4; i++) begin
			uc(mk(3'h1, 1'b0, 3'h0, 1'b0, 2'h2, h[i], 3'h4, i == 3), 1'b0, 8'h00, n);
			rchk("shift_result", `SRD_OFF_ACC3, r[i]);
			rchk("last_result", `SRD_OFF_RESULT, r[i]);
			chk("rbus_out", {8'h00, rbus}, {8'h00, r[i]});
		end
		$display("t_shift done");
	endtask
	task automatic t_flags;
		int n;
		wr(`SRD_OFF_STATUS, 8'h00);
		ld(3'h1, 8'h80);
		ld(3'h2, 8'h80);
		uc(mk(3'h1, 1'b0, 3'h2, 1'b0, 2'h3, 2'h0, 3'h3, 1'b0), 1'b0, 8'h00, n);
		rchk("add_flags", `SRD_OFF_STATUS, 8'h60);
		wr(`SRD_OFF_STATUS, 8'h1F);
		rchk("status_rw", `SRD_OFF_STATUS, 8'h1F);
		chk("status_out", {8'h00, status}, 16'h001F);
		uc(mk(3'h0, 1'b0, 3'h0, 1'b0, 2'h0, 2'h0, 3'h0, 1'b0), 1'b1, 8'h00, n);
		chk("mem_cycle_len", 16'(n + 1), 16'h000B);
		uc(mk(3'h0, 1'b0, 3'h0, 1'b0, 2'h0, 2'h0, 3'h0, 1'b0), 1'b0, 8'h00, n);
		chk("plain_cycle_len", 16'(n + 1), 16'h0008);
		$display("t_flags done");
	endtask
	task automatic t_stack;
		int n;
		for (int i = 0; i < 17; i++) begin
			uc(mk(3'h1, 1'b1, 3'h0, 1'b0, 2'h0, 2'h0, 3'h0, 1'b1), 1'b0, 8'h10 + i[7:0], n);
		end
		for (int i = 0; i < 17; i++) begin
			uc(mk(3'h0, 1'b1, 3'h0, 1'b0, 2'h2, 2'h0, 3'h1, 1'b0), 1'b0, 8'h00, n);
			rchk("stack_pop", `SRD_OFF_ACC0, i < 16 ? 8'h20 - i[7:0] : 8'h00);
		end
		wr(`SRD_OFF_MODE, 8'h01);
		wr(`SRD_OFF_STATUS, 8'hA0);
		uc(mk(3'h1, 1'b1, 3'h0, 1'b0, 2'h0, 2'h0, 3'h0, 1'b1), 1'b0, 8'h3C, n);
		uc(mk(3'h0, 1'b1, 3'h0, 1'b0, 2'h2, 2'h0, 3'h1, 1'b0), 1'b0, 8'h00, n);
		rchk("flag_view", `SRD_OFF_ACC0, 8'hAC);
		$display("t_stack done");
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_pc;
		t_alu;
		t_shift;
		t_flags;
		t_stack;
		finish_test;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		finish_test;
	end
endmodule
bind srd_datapath srd_datapath_chk i_srd_datapath_chk (.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n), .i_ctrl_nibble(i_ctrl_nibble), .i_mem_cycle(i_mem_cycle),
	.i_byte_fetched(i_byte_fetched), .i_skip(i_skip), .i_ext_data(i_ext_data),
	.i_page(i_page), .o_ring(o_ring), .o_phase_strobe_first(o_phase_strobe_first),
	.o_phase_strobe_third(o_phase_strobe_third), .o_phase_strobe_fifth(o_phase_strobe_fifth),
	.o_phase_strobe_seventh(o_phase_strobe_seventh), .o_data_out(o_data_out),
	.o_rbus_out(o_rbus_out), .o_mem_addr(o_mem_addr));
